// [rtl/dmr_consts.svh]
`ifndef DMR_CONSTS_SVH
`define DMR_CONSTS_SVH
// Command pins {cs_n, ras_n, cas_n, we_n}
`define DMR_CMD_REGSET     4'h0
`define DMR_CMD_REFRESH    4'h1
`define DMR_CMD_PRECHARGE  4'h2
`define DMR_CMD_NOP        4'h7
// Bank-address select codes
`define DMR_BA_MODE        2'h0
`define DMR_BA_EXT1        2'h1
`define DMR_BA_EXT2        2'h2
`define DMR_BA_EXT3        2'h3
// Mode register field positions
`define DMR_BL_LSB         0
`define DMR_ORDER_BIT      3
`define DMR_CL_LSB         4
`define DMR_TEST_BIT       7
`define DMR_DLLRST_BIT     8
`define DMR_WR_LSB         9
`define DMR_PDX_BIT        12
// Burst length codes
`define DMR_BL_CODE4       3'h2
`define DMR_BL_CODE8       3'h3
// Extended register one fields
`define DMR_DLL_DIS_BIT    0
`define DMR_IMP_LSB        7
`define DMR_IMP_DEFAULT    3'h7
`define DMR_IMP_EXIT       3'h0
// Register reset content (undefined in silicon; zero here)
`define DMR_REG_RESET      13'h0000
// Clocks after DLL reset before reads are safe
`define DMR_DLL_LOCK_CLKS  200
`define DMR_LOCK_W         8
`endif

// [rtl/dmr_pkg.sv]
package dmr_pkg;
	typedef enum logic [1:0] {
		DMR_BL4      = 2'h0,
		DMR_BL8      = 2'h1,
		DMR_BL_RSVD  = 2'h2
	} dmr_burst_len_t;

	typedef struct packed {
		logic [2:0] cnt;
		logic [2:0] start;
		logic       eight;
		logic       interleave;
		logic       busy;
	} dmr_seq_state_t;
endpackage

// [rtl/dmr_burst_if.sv]
`timescale 1ns/10ps
interface dmr_burst_if;
	logic       start;
	logic [2:0] start_col;
	logic       eight;
	logic       interleave;
	logic       beat_valid;
	logic [2:0] beat_col;
	logic       last;
	modport ctrl (output start, output start_col, output eight, output interleave,
		input beat_valid, input beat_col, input last);
	modport seq (input start, input start_col, input eight, input interleave,
		output beat_valid, output beat_col, output last);
endinterface

// [rtl/dmr_burst_seq.sv]
`timescale 1ns/10ps
module dmr_burst_seq
	import dmr_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic resetn,
	// Sequencing
	dmr_burst_if.seq  bus
);
	dmr_seq_state_t s_q;
	dmr_seq_state_t s_d;
	logic [2:0]     nxt_col;

	// Column offset for a beat; sequential wraps inside a nibble
	function automatic logic [2:0] dmr_col(input logic [2:0] st, input logic [2:0] beat,
		input logic il, input logic eight);
		logic [2:0] c;
		c = 3'h0;
		if (il)
			c = st ^ beat;
		else
		begin
			c[1:0] = 2'(st[1:0] + beat[1:0]);
			c[2]   = st[2] ^ beat[2];
		end
		if (!eight)
			c[2] = st[2];
		return c;
	endfunction

	always_comb
	begin
		s_d = s_q;
		nxt_col = 3'h0;
		if (bus.start)
		begin
			s_d.busy       = 1'b1;
			s_d.start      = bus.start_col;
			s_d.eight      = bus.eight;
			s_d.interleave = bus.interleave;
			s_d.cnt        = 3'h0;
		end
		else if (s_q.busy)
		begin
			s_d.cnt = 3'(s_q.cnt + 3'h1);
			if (s_q.cnt == (s_q.eight ? 3'h7 : 3'h3))
				s_d.busy = 1'b0;
		end
		nxt_col = dmr_col(s_q.start, s_q.cnt, s_q.interleave, s_q.eight);
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign bus.beat_valid = s_q.busy;
	assign bus.beat_col   = nxt_col;
	assign bus.last       = s_q.busy && (s_q.cnt == (s_q.eight ? 3'h7 : 3'h3));
endmodule

// [rtl/dmr_mode_ctrl.sv]
// Contract
// - Both bank bits pick the target register
// - Register write replaces every field
// - Register writes never touch array contents
// - All-low command and banks writes mode
// - Burst length in bits 0 to 2
// - Bit 3 picks sequential or interleaved
// - Bits 4 to 6 give latency 3-7
// - Bit 8 set resets the DLL
// - Bits 9 to 11 give write recovery
// - Bit 12 selects fast or slow exit
// - Burst eight orders by nibble or XOR
// - Start 5 gives documented eight-beat orders
// - Bank code one writes ext register one
`timescale 1ns/10ps
`include "dmr_consts.svh"
module dmr_mode_ctrl
	import dmr_pkg::*;
#(
	parameter int LOCK_CLKS = `DMR_DLL_LOCK_CLKS
)
(
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                resetn,
	// Command pins
	input  wire logic                cke,
	input  wire logic                cs_n,
	input  wire logic                ras_n,
	input  wire logic                cas_n,
	input  wire logic                we_n,
	input  wire logic [1:0]          ba,
	input  wire logic [12:0]         addr,
	// Burst request from the column path
	input  wire logic                burst_start,
	input  wire logic [2:0]          burst_col,
	// Register contents and decoded mode fields
	output logic [12:0]              operating_mode_config,
	output logic [12:0]              ext_config_reg_one,
	output logic [12:0]              ext_config_reg_two,
	output logic [12:0]              ext_config_reg_three,
	output dmr_pkg::dmr_burst_len_t  burst_len,
	output logic                     burst_order_select,
	output logic [2:0]               cas_latency,
	output logic                     cas_latency_valid,
	output logic                     test_mode_bit,
	output logic [2:0]               write_recovery,
	output logic                     write_recovery_valid,
	output logic                     powerdown_exit_select,
	output logic [2:0]               driver_impedance_calibration,
	// Status
	output logic                     dll_reset_pulse,
	output logic                     dll_locked,
	output logic                     regs_written,
	output logic                     refresh_seen,
	// Burst beats
	output logic                     beat_valid,
	output logic [2:0]               beat_col,
	output logic                     beat_last
);
	import dmr_pkg::*;

	// Lock counter width caps the settle time
	if (LOCK_CLKS < 1 || LOCK_CLKS > 255)
	begin : g_lock_range
		$error("LOCK_CLKS out of range");
	end

	typedef struct packed {
		logic [12:0]    opcfg;
		logic [12:0]    e1;
		logic [12:0]    e2;
		logic [12:0]    e3;
		dmr_burst_len_t bl;
		logic [2:0]     cl;
		logic           cl_ok;
		logic [2:0]     wr;
		logic           wr_ok;
		logic           dll_rst;
		logic [`DMR_LOCK_W-1:0] lock_cnt;
		logic           locked;
		logic [3:0]     written;
		logic           refreshed;
		logic           all_wr;
		logic           bstart;
		logic [2:0]     bcol;
		logic           bvalid;
		logic [2:0]     bbeat;
		logic           blast;
	} dmr_ctrl_state_t;

	dmr_ctrl_state_t s_q;
	dmr_ctrl_state_t s_d;
	dmr_burst_if     bif ();
	logic [3:0]      cmd;
	logic            is_regset;

	function automatic dmr_burst_len_t dmr_bl_decode(input logic [2:0] code);
		unique case (code)
			`DMR_BL_CODE4: return DMR_BL4;
			`DMR_BL_CODE8: return DMR_BL8;
			default:       return DMR_BL_RSVD;
		endcase
	endfunction

	assign cmd       = {cs_n, ras_n, cas_n, we_n};
	assign is_regset = cke && (cmd == `DMR_CMD_REGSET);

	always_comb
	begin
		s_d = s_q;
		s_d.dll_rst = 1'b0;
		s_d.bstart  = burst_start;
		s_d.bcol    = burst_col;
		// Only register state moves; no path reaches the array
		if (is_regset)
		begin
			unique case (ba)
				`DMR_BA_MODE:
				begin
					s_d.opcfg = addr;
					s_d.bl = dmr_bl_decode(addr[`DMR_BL_LSB +: 3]);
					s_d.cl = addr[`DMR_CL_LSB +: 3];
					s_d.cl_ok = (addr[`DMR_CL_LSB +: 3] >= 3'h3);
					s_d.wr = 3'(addr[`DMR_WR_LSB +: 3] + 3'h1);
					s_d.wr_ok = (addr[`DMR_WR_LSB +: 3] >= 3'h1)
						&& (addr[`DMR_WR_LSB +: 3] <= 3'h5);
					s_d.written[0] = 1'b1;
					if (addr[`DMR_DLLRST_BIT])
					begin
						s_d.dll_rst  = 1'b1;
						s_d.locked   = 1'b0;
						s_d.lock_cnt = '0;
					end
				end
				`DMR_BA_EXT1:
				begin
					s_d.e1 = addr;
					s_d.written[1] = 1'b1;
				end
				`DMR_BA_EXT2:
				begin
					s_d.e2 = addr;
					s_d.written[2] = 1'b1;
				end
				`DMR_BA_EXT3:
				begin
					s_d.e3 = addr;
					s_d.written[3] = 1'b1;
				end
			endcase
		end
		// Registered so the status output leaves a flip-flop
		s_d.all_wr = &s_d.written;
		// Lock counter runs until the DLL has had its settle time
		if (!s_q.locked && !s_d.dll_rst && s_q.written[0])
		begin
			if (s_q.lock_cnt == `DMR_LOCK_W'(LOCK_CLKS - 1))
				s_d.locked = 1'b1;
			else
				s_d.lock_cnt = `DMR_LOCK_W'(s_q.lock_cnt + 1'b1);
		end
		if (cke && cmd == `DMR_CMD_REFRESH)
			s_d.refreshed = 1'b1;
		s_d.bvalid = bif.beat_valid;
		s_d.bbeat  = bif.beat_col;
		s_d.blast  = bif.last;
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_q    <= '0;
			s_q.opcfg <= `DMR_REG_RESET;
			s_q.bl <= DMR_BL_RSVD;
		end
		else
			s_q <= s_d;
	end

	// Burst setup only samples the register; overlapping start restarts it
	assign bif.start      = s_q.bstart && (s_q.bl != DMR_BL_RSVD);
	assign bif.start_col  = s_q.bcol;
	assign bif.eight      = (s_q.bl == DMR_BL8);
	assign bif.interleave = s_q.opcfg[`DMR_ORDER_BIT];

	dmr_burst_seq u_seq (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.bus     (bif.seq)
	);

	assign operating_mode_config        = s_q.opcfg;
	assign ext_config_reg_one           = s_q.e1;
	assign ext_config_reg_two           = s_q.e2;
	assign ext_config_reg_three         = s_q.e3;
	assign burst_len                    = s_q.bl;
	assign burst_order_select           = s_q.opcfg[`DMR_ORDER_BIT];
	assign cas_latency                  = s_q.cl;
	assign cas_latency_valid            = s_q.cl_ok;
	assign test_mode_bit                = s_q.opcfg[`DMR_TEST_BIT];
	assign write_recovery               = s_q.wr;
	assign write_recovery_valid         = s_q.wr_ok;
	assign powerdown_exit_select        = s_q.opcfg[`DMR_PDX_BIT];
	assign driver_impedance_calibration = s_q.e1[`DMR_IMP_LSB +: 3];
	assign dll_reset_pulse              = s_q.dll_rst;
	assign dll_locked                   = s_q.locked;
	assign regs_written                 = s_q.all_wr;
	assign refresh_seen                 = s_q.refreshed;
	assign beat_valid                   = s_q.bvalid;
	assign beat_col                     = s_q.bbeat;
	assign beat_last                    = s_q.blast;
endmodule

// [verification/dmr_mode_ctrl_assertions.sv]
`timescale 1ns/10ps
module dmr_mode_ctrl_chk
(
	// Clock and reset
	input wire logic                 ref_clk,
	input wire logic                 resetn,
	// Command pins
	input wire logic                 cke,
	input wire logic                 cs_n,
	input wire logic                 ras_n,
	input wire logic                 cas_n,
	input wire logic                 we_n,
	input wire logic [1:0]           ba,
	input wire logic [12:0]          addr,
	// Outputs
	input wire logic [12:0]          operating_mode_config,
	input wire logic [12:0]          ext_config_reg_one,
	input dmr_pkg::dmr_burst_len_t   burst_len,
	input wire logic                 burst_order_select,
	input wire logic                 cas_latency_valid,
	input wire logic                 write_recovery_valid,
	input wire logic                 dll_reset_pulse
);
	import dmr_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	sequence s_wr(b);
		cke && !cs_n && !ras_n && !cas_n && !we_n && ba == b;
	endsequence
	sequence s_mode;
		s_wr(2'h0);
	endsequence
	chk_mode_load: assert property (s_mode |=> operating_mode_config == $past(addr))
		else $error("mode register not loaded");
	chk_ext_one_load: assert property (s_wr(2'h1) |=>
		ext_config_reg_one == $past(addr))
		else $error("ext register one not loaded");
	chk_dll_pulse: assert property (s_mode ##0 addr[8] |=>
		dll_reset_pulse ##1 !dll_reset_pulse)
		else $error("dll reset pulse wrong");
	chk_bl_eight: assert property (s_mode ##0 addr[2:0] == 3'h3 |=> burst_len == DMR_BL8)
		else $error("burst eight not decoded");
	chk_bl_reserved: assert property (s_mode ##0 !(addr[2:0] inside {3'h2, 3'h3})
		|=> burst_len == DMR_BL_RSVD)
		else $error("reserved length not flagged");
	chk_order_bit: assert property (s_mode |=> burst_order_select == $past(addr[3]))
		else $error("order bit wrong");
	chk_latency_ok: assert property (s_mode |=>
		cas_latency_valid == ($past(addr[6:4]) >= 3'h3))
		else $error("latency valid wrong");
	chk_wr_recovery: assert property (s_mode |=> write_recovery_valid ==
		($past(addr[11:9]) != 3'h0 && $past(addr[11:9]) < 3'h6))
		else $error("recovery valid wrong");
	chk_cke_refuse: assert property (!cke |=> $stable(operating_mode_config))
		else $error("write taken with clock-enable low");
endmodule
bind dmr_mode_ctrl dmr_mode_ctrl_chk dmr_mode_ctrl_chk_i (.ref_clk, .resetn, .cke, .cs_n,
	.ras_n, .cas_n, .we_n, .ba, .addr, .operating_mode_config, .ext_config_reg_one, .burst_len,
	.burst_order_select, .cas_latency_valid, .write_recovery_valid, .dll_reset_pulse);

// [verification/dmr_host_model.sv]
`timescale 1ns/10ps
`include "dmr_consts.svh"
module dmr_host_model
(
	// Clock
	input wire logic    ref_clk,
	// Command pins {cs_n, ras_n, cas_n, we_n}
	output logic        cke,
	output logic [3:0]  cmd,
	output logic [1:0]  ba,
	output logic [12:0] addr
);
	initial
	begin
		cke  = 1'b0;
		cmd  = 4'hf;
		ba   = 2'h0;
		addr = 13'h0000;
	end
	task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
		@(posedge ref_clk);
		#1;
		cmd  = c;
		ba   = b;
		addr = a;
		@(posedge ref_clk);
		#1;
		cmd  = 4'hf;
		addr = ~a;
	endtask
	task automatic init(input logic [12:0] mode);
		repeat (20000) @(posedge ref_clk);
		#1;
		cke = 1'b1;
		repeat (40) @(posedge ref_clk);
		issue(`DMR_CMD_PRECHARGE, 2'h0, 13'h0400);
		issue(`DMR_CMD_REGSET, `DMR_BA_EXT2, 13'h0000);
		issue(`DMR_CMD_REGSET, `DMR_BA_EXT3, 13'h0000);
		issue(`DMR_CMD_REGSET, `DMR_BA_EXT1, 13'h0000);
		issue(`DMR_CMD_REGSET, `DMR_BA_MODE, (mode & 13'h1e7f) | 13'h0100);
		issue(`DMR_CMD_PRECHARGE, 2'h0, 13'h0400);
		repeat (2) issue(`DMR_CMD_REFRESH, 2'h0, 13'h0000);
		issue(`DMR_CMD_REGSET, `DMR_BA_MODE, mode & 13'h1e7f);
		repeat (200) @(posedge ref_clk);
		issue(`DMR_CMD_REGSET, `DMR_BA_EXT1, 13'h0380);
		issue(`DMR_CMD_REGSET, `DMR_BA_EXT1, 13'h0000);
	endtask
endmodule

// [verification/testbench.sv]
`timescale 1ns/10ps
`include "dmr_consts.svh"
module testbench;
	import dmr_pkg::*;
	logic                   ref_clk = 1'b0;
	logic                   resetn, burst_start, cke, beat_valid, beat_last;
	logic [2:0]             burst_col, beat_col, cas_latency, write_recovery;
	logic [2:0]             driver_impedance_calibration;
	logic [3:0]             cmd;
	logic [1:0]             ba;
	logic [12:0]            addr, operating_mode_config, ext_config_reg_one;
	logic [12:0]            ext_config_reg_two, ext_config_reg_three, regs [4];
	dmr_burst_len_t         burst_len;
	logic                   burst_order_select, cas_latency_valid, test_mode_bit;
	logic                   write_recovery_valid, powerdown_exit_select, dll_reset_pulse;
	logic                   dll_locked, regs_written, refresh_seen;
	int                     bad_count, compares, seed;
	logic [31:0]            r;
	always #5 ref_clk = ~ref_clk;
	dmr_host_model dmr_host_model_i (.ref_clk, .cke, .cmd, .ba, .addr);
	dmr_mode_ctrl #(.LOCK_CLKS(8)) dmr_mode_ctrl_i (.ref_clk, .resetn, .cke, .cs_n(cmd[3]),
		.ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]), .ba, .addr, .burst_start, .burst_col,
		.operating_mode_config, .ext_config_reg_one, .ext_config_reg_two, .ext_config_reg_three,
		.burst_len, .burst_order_select, .cas_latency, .cas_latency_valid, .test_mode_bit,
		.write_recovery, .write_recovery_valid, .powerdown_exit_select,
		.driver_impedance_calibration, .dll_reset_pulse, .dll_locked, .regs_written,
		.refresh_seen, .beat_valid, .beat_col, .beat_last);
	function automatic logic [2:0] exp_col(input logic [2:0] s, input logic [2:0] i,
		input logic il, input logic e);
		if (il)
			return e ? s ^ i : {s[2], s[1:0] ^ i[1:0]};
		return {s[2] ^ (e & i[2]), s[1:0] + i[1:0]};
	endfunction
	task automatic check(input string what, input logic [12:0] exp, input logic [12:0] got);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic burst(input logic [2:0] s, input logic il, input logic e);
		int n;
		n = 0;
		@(posedge ref_clk);
		#1;
		burst_start = 1'b1;
		burst_col   = s;
		@(posedge ref_clk);
		#1;
		burst_start = 1'b0;
		while (beat_valid !== 1'b1 && n < 10)
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		for (int i = 0; i < (e ? 8 : 4); i++)
		begin
			check("beat valid", 1'b1, beat_valid);
			check("beat col", exp_col(s, i[2:0], il, e), beat_col);
			check("beat last", i == (e ? 7 : 3), beat_last);
			@(posedge ref_clk);
			#1;
		end
	endtask
	task automatic finish_test;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#400000;
		bad_count++;
		finish_test();
	end
	initial
	begin
		seed = 32'hb4ee;
		resetn = 1'b0;
		burst_start = 1'b0;
		burst_col = 3'h0;
		repeat (10) @(posedge ref_clk);
		#1;
		resetn = 1'b1;
		dmr_host_model_i.init(13'h0a53);
		regs = '{13'h0a53, 13'h0000, 13'h0000, 13'h0000};
		check("all written", 1'b1, regs_written);
		check("refresh", 1'b1, refresh_seen);
		check("dll locked", 1'b1, dll_locked);
		$display("init test done");
		for (int k = 0; k < 40; k++)
		begin
			r = $random(seed);
			dmr_host_model_i.issue(`DMR_CMD_REGSET, r[14:13], r[12:0]);
			regs[r[14:13]] = r[12:0];
			check("mode reg", regs[0], operating_mode_config);
			check("ext one", regs[1], ext_config_reg_one);
			check("ext two", regs[2], ext_config_reg_two);
			check("ext three", regs[3], ext_config_reg_three);
			check("dll pulse", r[14:13] == 2'h0 && r[8], dll_reset_pulse);
			if (r[14:13] == 2'h0 && r[8])
				check("lock clear", 1'b0, dll_locked);
			check("length", regs[0][2:1] != 2'h1 ? 2'h2 : regs[0][0], burst_len);
			check("order", regs[0][3], burst_order_select);
			check("latency", regs[0][6:4], cas_latency);
			check("latency ok", regs[0][6:4] >= 3'h3, cas_latency_valid);
			check("recovery", 3'(regs[0][11:9] + 3'h1), write_recovery);
			check("recovery ok", regs[0][11:9] inside {[3'h1:3'h5]}, write_recovery_valid);
			check("power exit", regs[0][12], powerdown_exit_select);
			check("test bit", regs[0][7], test_mode_bit);
			check("impedance", regs[1][9:7], driver_impedance_calibration);
		end
		dmr_host_model_i.cke = 1'b0;
		dmr_host_model_i.issue(`DMR_CMD_REGSET, 2'h0, ~regs[0]);
		check("cke refuse", regs[0], operating_mode_config);
		dmr_host_model_i.cke = 1'b1;
		$display("register test done");
		for (int t = 0; t < 32; t++)
		begin
			r = t;
			dmr_host_model_i.issue(`DMR_CMD_REGSET, 2'h0, {9'h0a5, r[3], 2'h1, r[4]});
			burst(r[2:0], r[3], r[4]);
		end
		// Reserved length must swallow a burst request
		dmr_host_model_i.issue(`DMR_CMD_REGSET, `DMR_BA_MODE, 13'h0a50);
		check("length rsvd", 2'h2, burst_len);
		burst_start = 1'b1;
		burst_col   = 3'h5;
		@(posedge ref_clk);
		#1;
		burst_start = 1'b0;
		repeat (6)
		begin
			@(posedge ref_clk);
			#1;
			check("refused beat", 1'b0, beat_valid);
		end
		$display("burst test done");
		finish_test();
	end
endmodule
